// file: sgisre_pkg.sv
// package for the cpu-interface generate and interface-enable registers
// assumes one core clock, synchronous active-low reset
// Function
// - group1 generate register is 64-bit write-only; each write not undefined or trapped requests interrupts
// - interrupt identifier comes from bits 27:24 of the written value
// - affinity path from bits 55:48, 39:32 and 23:16
// - bit 40 zero targets affinity plus mask, one broadcasts excluding self
// - target mask bit n selects element with level-0 affinity n
// - non-secure level-1 writes trap to hypervisor on route overrides or either trap bit (common-register or group1/2)
// - monitor routing fiq and irq traps secure level-1 and level-2 writes
// - enable bit zero makes level-1 generate writes undefined
// - enable register is 32 bits; bits 31:3 read zero
// - bit 2 disables irq bypass when one
// - bit 1 disables fiq bypass when one
// - without a bypass path the disable bit reads one, ignores writes
// - writable enable and bypass bits reset to zero
// - bypass bits alias monitor or hypervisor copy, read-only or read-write
// - enable zero makes level-1 access to other interface registers undefined
// - virtual accesses to enable bit use the virtual enable field
// - system-register-only interface makes enable read one, ignore writes
// - level-1 enable access traps to monitor or hypervisor on zero enables
package sgisre_pkg;
   localparam int SGI_INTERRUPT_IDENTIFIER_LSB = 24;
   localparam int SGI_AFFINITY_LEVEL1_LSB  = 16;
   localparam int SGI_AFFINITY_LEVEL2_LSB  = 32;
   localparam int SGI_AFFINITY_LEVEL3_LSB  = 48;
   localparam int SGI_IRM_BIT   = 40;
   localparam int SRE_EN_BIT    = 0;
   localparam int SRE_DFB_BIT   = 1;
   localparam int SRE_DIB_BIT   = 2;
   localparam logic [31:0] SRE_RESET = 32'h0000_0000;
   localparam logic        BIT_RESET = 1'b0;

   typedef enum logic [1:0] {EL0, EL1, EL2, EL3} sgisre_el_e;

   typedef enum logic [2:0] {
      SGISRE_OK, SGISRE_UNDEF, SGISRE_TRAP_HYP, SGISRE_TRAP_MON, SGISRE_VIRT
   } sgisre_res_e;

   // system state controlling traps and aliasing
   typedef struct packed {
      logic       el3_present;
      logic       el2_present;
      logic       single_security_flag;
      logic       secure;
      sgisre_el_e el;
      logic       hyp_fiq_route_override;
      logic       hyp_irq_route_override;
      logic       hyp_trap_group12;
      logic       hyp_common_reg_trap;
      logic       monitor_fiq_route;
      logic       monitor_irq_route;
      logic       monitor_level_enable;
      logic       hyp_level_enable;
      logic       mon_irq_bypass_disable;
      logic       mon_fiq_bypass_disable;
      logic       hyp_irq_bypass_disable;
      logic       hyp_fiq_bypass_disable;
   } sgisre_ctx_s;

   // request forwarded to the distributor
   typedef struct packed {
      logic [3:0]  interrupt_identifier;
      logic        routing_mode_bit;
      logic [7:0]  affinity_level3;
      logic [7:0]  affinity_level2;
      logic [7:0]  affinity_level1;
      logic [15:0] target_pe_mask;
      logic        secure;
   } sgisre_req_s;
endpackage : sgisre_pkg

// file: sgisre_top.sv
// generate-register write path and interface-enable register
// assumes the core presents one access per cycle with context alongside
module sgisre_top
   import sgisre_pkg::*;
#(
   parameter bit HAS_IRQ_BYPASS = 1'b1,
   parameter bit HAS_FIQ_BYPASS = 1'b1,
   parameter bit SYSREG_ONLY    = 1'b0
)(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // core access
   input  wire logic        i_sgi_wr,
   input  wire logic [63:0] i_sgi_wdata,
   input  wire logic        i_sre_wr,
   input  wire logic        i_sre_rd,
   input  wire logic [31:0] i_sre_wdata,
   input  wire logic        i_other_acc,
   input  wire logic        i_virtual,
   input  wire logic        i_virt_enable,
   input  wire sgisre_ctx_s i_ctx,
   // core answer
   output logic             o_done,
   output sgisre_res_e      o_result,
   output logic [31:0]      o_sre_rdata,
   output logic             o_virt_enable_wr,
   output logic             o_virt_enable_val,
   output logic             o_interface_enable,
   output logic             o_irq_bypass_disable,
   output logic             o_fiq_bypass_disable,
   // distributor request
   output logic             o_req_valid,
   output sgisre_req_s      o_req
);
   logic        en_q, en_d, dib_q, dib_d, dfb_q, dfb_d;
   logic        done_q, done_d, vw_q, vw_d, vv_q, vv_d, rv_q, rv_d;
   sgisre_res_e res_q, res_d;
   logic [31:0] rd_q, rd_d;
   sgisre_req_s req_q, req_d;
   logic        ns_el1, sec_low, mon_rw, alias_mon, en_eff, dib_eff, dfb_eff;
   sgisre_res_e sgi_res, sre_res, oth_res;

   always_comb begin
      ns_el1    = !i_ctx.secure && i_ctx.el == EL1;
      sec_low   = (i_ctx.secure && i_ctx.el == EL1) || i_ctx.el == EL2;
      alias_mon = i_ctx.el3_present && !i_ctx.single_security_flag;
      mon_rw    = i_ctx.el3_present && i_ctx.single_security_flag
                  && !i_ctx.el2_present;
      en_eff    = SYSREG_ONLY ? 1'b1 : en_q;
      dib_eff   = !HAS_IRQ_BYPASS ? 1'b1 : mon_rw ? dib_q :
                  alias_mon ? i_ctx.mon_irq_bypass_disable :
                  i_ctx.hyp_irq_bypass_disable;
      dfb_eff   = !HAS_FIQ_BYPASS ? 1'b1 : mon_rw ? dfb_q :
                  alias_mon ? i_ctx.mon_fiq_bypass_disable :
                  i_ctx.hyp_fiq_bypass_disable;
      // generate write checks, undefined first then traps
      sgi_res = SGISRE_OK;
      if (i_ctx.el == EL1 && !en_eff)
         sgi_res = SGISRE_UNDEF;
      else if (ns_el1 && (i_ctx.hyp_fiq_route_override
               || i_ctx.hyp_irq_route_override
               || i_ctx.hyp_common_reg_trap || i_ctx.hyp_trap_group12))
         sgi_res = SGISRE_TRAP_HYP;
      else if (sec_low && i_ctx.monitor_fiq_route
               && i_ctx.monitor_irq_route)
         sgi_res = SGISRE_TRAP_MON;
      sre_res = SGISRE_OK;
      if (i_virtual)
         sre_res = SGISRE_VIRT;
      else if (i_ctx.el == EL1 && !i_ctx.monitor_level_enable)
         sre_res = SGISRE_TRAP_MON;
      else if (ns_el1 && (!i_ctx.hyp_level_enable || i_ctx.hyp_trap_group12))
         sre_res = SGISRE_TRAP_HYP;
      oth_res = (i_ctx.el == EL1 && !en_eff) ? SGISRE_UNDEF
                                             : SGISRE_OK;
   end

   always_comb begin
      en_d = en_q; dib_d = dib_q; dfb_d = dfb_q;
      done_d = 1'b0; res_d = SGISRE_OK; rd_d = rd_q;
      vw_d = 1'b0; vv_d = vv_q; rv_d = 1'b0; req_d = req_q;
      if (i_sgi_wr) begin
         done_d = 1'b1;
         res_d  = sgi_res;
         if (sgi_res == SGISRE_OK) begin
            rv_d = 1'b1;
            req_d.interrupt_identifier =
               i_sgi_wdata[SGI_INTERRUPT_IDENTIFIER_LSB +: 4];
            req_d.routing_mode_bit = i_sgi_wdata[SGI_IRM_BIT];
            req_d.secure = i_ctx.secure;
            if (i_sgi_wdata[SGI_IRM_BIT]) begin
               req_d.affinity_level3 = 8'h00;
               req_d.affinity_level2 = 8'h00;
               req_d.affinity_level1 = 8'h00;
               req_d.target_pe_mask  = 16'h0000;
            end else begin
               req_d.affinity_level3 = i_sgi_wdata[SGI_AFFINITY_LEVEL3_LSB +: 8];
               req_d.affinity_level2 = i_sgi_wdata[SGI_AFFINITY_LEVEL2_LSB +: 8];
               req_d.affinity_level1 =
                  i_sgi_wdata[SGI_AFFINITY_LEVEL1_LSB +: 8];
               req_d.target_pe_mask = i_sgi_wdata[15:0];
            end
         end
      end else if (i_sre_wr || i_sre_rd) begin
         done_d = 1'b1;
         res_d  = sre_res;
         if (sre_res == SGISRE_VIRT) begin
            rd_d = {31'h0000_0000, i_virt_enable};
            if (i_sre_wr) begin
               vw_d = 1'b1;
               vv_d = i_sre_wdata[SRE_EN_BIT];
            end
         end else if (sre_res == SGISRE_OK) begin
            if (i_sre_wr) begin
               if (!SYSREG_ONLY)
                  en_d = i_sre_wdata[SRE_EN_BIT];
               if (mon_rw) begin
                  dib_d = i_sre_wdata[SRE_DIB_BIT];
                  dfb_d = i_sre_wdata[SRE_DFB_BIT];
               end
            end
            rd_d = {29'h0000_0000, dib_eff, dfb_eff, en_eff};
         end
      end else if (i_other_acc) begin
         done_d = 1'b1;
         res_d  = oth_res;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         en_q   <= BIT_RESET;
         dib_q  <= BIT_RESET;
         dfb_q  <= BIT_RESET;
         done_q <= 1'b0;
         res_q  <= SGISRE_OK;
         rd_q   <= SRE_RESET;
         vw_q   <= 1'b0;
         vv_q   <= 1'b0;
         rv_q   <= 1'b0;
         req_q  <= '0;
      end else begin
         en_q   <= en_d;
         dib_q  <= dib_d;
         dfb_q  <= dfb_d;
         done_q <= done_d;
         res_q  <= res_d;
         rd_q   <= rd_d;
         vw_q   <= vw_d;
         vv_q   <= vv_d;
         rv_q   <= rv_d;
         req_q  <= req_d;
      end
   end

   // mirrors of the live enable state, registered
   logic en_o_q, dib_o_q, dfb_o_q;
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         en_o_q  <= 1'b0;
         dib_o_q <= 1'b0;
         dfb_o_q <= 1'b0;
      end else begin
         en_o_q  <= SYSREG_ONLY ? 1'b1 : en_d;
         dib_o_q <= HAS_IRQ_BYPASS ? dib_d : 1'b1;
         dfb_o_q <= HAS_FIQ_BYPASS ? dfb_d : 1'b1;
      end
   end

   assign o_done               = done_q;
   assign o_result             = res_q;
   assign o_sre_rdata          = rd_q;
   assign o_virt_enable_wr     = vw_q;
   assign o_virt_enable_val    = vv_q;
   assign o_interface_enable   = en_o_q;
   assign o_irq_bypass_disable = dib_o_q;
   assign o_fiq_bypass_disable = dfb_o_q;
   assign o_req_valid          = rv_q;
   assign o_req                = req_q;
endmodule : sgisre_top

// file: sgisre_monitor.sv
// checker on the generate-write ports of sgisre_top
// assumes a bind onto sgisre_top and one clock
module sgisre_monitor
   import sgisre_pkg::*;
(
   // watched ports
   input wire logic        i_mclk,
   input wire logic        i_reset_n,
   input wire logic        i_sgi_wr,
   input wire logic [63:0] i_sgi_wdata,
   input wire sgisre_ctx_s i_ctx,
   input wire logic        o_done,
   input wire sgisre_res_e o_result,
   input wire logic        o_interface_enable,
   input wire logic        o_req_valid,
   input wire sgisre_req_s o_req
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   wire w1 = i_sgi_wr && i_ctx.el == EL1;
   property p_done; i_sgi_wr |=> o_done; endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_req; o_req_valid == (o_done && o_result == SGISRE_OK
      && $past(i_sgi_wr)); endproperty
   a_req: assert property (p_req) else $error("bad valid");
   property p_id; o_req_valid |-> o_req.interrupt_identifier
      == $past(i_sgi_wdata[27:24]); endproperty
   a_id: assert property (p_id) else $error("bad id");
   property p_aff; o_req_valid && !o_req.routing_mode_bit |-> o_req[40:1]
      == $past({i_sgi_wdata[55:48], i_sgi_wdata[39:32], i_sgi_wdata[23:0]});
   endproperty
   a_aff: assert property (p_aff) else $error("bad path");
   property p_bc; o_req_valid |-> o_req.routing_mode_bit ==
      $past(i_sgi_wdata[40]) && (!o_req[41] || !o_req[40:1]); endproperty
   a_bc: assert property (p_bc) else $error("bad mode");
   property p_ud; w1 && !o_interface_enable |=> o_result == SGISRE_UNDEF;
   endproperty
   a_ud: assert property (p_ud) else $error("no undef");
   property p_hy; w1 && o_interface_enable && !i_ctx.secure &&
      (i_ctx.hyp_fiq_route_override || i_ctx.hyp_irq_route_override ||
      i_ctx.hyp_common_reg_trap) |=> o_result == SGISRE_TRAP_HYP; endproperty
   a_hy: assert property (p_hy) else $error("no hyp trap");
   property p_mn; i_sgi_wr && i_ctx.secure && i_ctx.monitor_fiq_route &&
      i_ctx.monitor_irq_route && (i_ctx.el == EL2 || w1 && o_interface_enable)
      |=> o_result == SGISRE_TRAP_MON; endproperty
   a_mn: assert property (p_mn) else $error("no mon trap");
   c_bc: cover property (o_req_valid && o_req.routing_mode_bit);
   c_ud: cover property (o_done && o_result == SGISRE_UNDEF);
   c_mn: cover property (o_done && o_result == SGISRE_TRAP_MON);
endmodule : sgisre_monitor
bind sgisre_top sgisre_monitor sgisre_monitor_i (.*);

// file: sgisre_dist_model.sv
// distributor stand-in: counts requests it can deliver
// assumes one-cycle request pulses, eight elements per cluster
module sgisre_dist_model
   import sgisre_pkg::*;
(
   // request in, delivery count out
   input  wire logic        i_mclk,
   input  wire logic        i_req_valid,
   input  wire sgisre_req_s i_req,
   output int               o_count = 0
);
   always @(posedge i_mclk)
      if (i_req_valid && (i_req.routing_mode_bit || |i_req[8:1]))
         o_count <= o_count + 1;
endmodule : sgisre_dist_model

// file: sgisre_tb.sv
// bench: core accesses to the generate and enable registers
// assumes default parameters for sgisre_top_i, so both bypass paths exist there
module tb;
   import sgisre_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_sgi_wr = 1'b0;
   logic        i_sre_wr = 1'b0, i_sre_rd = 1'b0, i_other_acc = 1'b0;
   logic        i_virtual = 1'b0, i_virt_enable = 1'b1, o_done;
   logic        o_virt_enable_wr, o_virt_enable_val, o_interface_enable;
   logic        o_irq_bypass_disable, o_fiq_bypass_disable, o_req_valid;
   logic [63:0] i_sgi_wdata = 64'h0;
   logic [31:0] i_sre_wdata = 32'h0, o_sre_rdata;
   sgisre_ctx_s i_ctx = '0;
   sgisre_res_e o_result;
   sgisre_req_s o_req;
   int          count, fail_count = 0, cmp_count = 0;
   logic        ro_en, ro_dib, ro_dfb;
   sgisre_top sgisre_top_i (.*);
   // variant with no bypass paths and a system-register-only interface
   sgisre_top #(.HAS_IRQ_BYPASS(1'b0), .HAS_FIQ_BYPASS(1'b0),
      .SYSREG_ONLY(1'b1)) sgisre_top_ro_i (.*, .o_done(), .o_result(),
      .o_sre_rdata(), .o_virt_enable_wr(), .o_virt_enable_val(),
      .o_interface_enable(ro_en), .o_irq_bypass_disable(ro_dib),
      .o_fiq_bypass_disable(ro_dfb), .o_req_valid(), .o_req());
   sgisre_dist_model sgisre_dist_model_i (.i_mclk(i_mclk),
      .i_req_valid(o_req_valid), .i_req(o_req), .o_count(count));
   always #10 i_mclk = ~i_mclk;
   task automatic cmp(input string n, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e) fail_count++;
      if (g !== e) $display("mismatch %s exp %h got %h", n, e, g);
   endtask : cmp
   task automatic finish_test;
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic acc(input int k, input logic [63:0] d,
      input sgisre_res_e r, input logic [31:0] rd);
      @(negedge i_mclk);
      {i_sgi_wdata, i_sre_wdata} = {d, d[31:0]};
      {i_sgi_wr, i_sre_wr, i_sre_rd, i_other_acc} = 4'h8 >> k;
      @(negedge i_mclk);
      {i_sgi_wr, i_sre_wr, i_sre_rd, i_other_acc} = 4'h0;
      cmp("answer", {1'b1, r}, {o_done, o_result});
      cmp("valid", k == 0 && r == SGISRE_OK, o_req_valid);
      if (k == 2 && r inside {SGISRE_OK, SGISRE_VIRT})
         cmp("rdata", rd, o_sre_rdata);
   endtask : acc
   initial begin
      #20us fail_count++;
      finish_test();
   end
   initial begin
      i_ctx = '{el3_present: 1'b1, single_security_flag: 1'b1, secure: 1'b1,
         el: EL1, monitor_level_enable: 1'b1, hyp_level_enable: 1'b1,
         default: '0};
      repeat (3) @(negedge i_mclk);
      i_reset_n = 1'b1;
      acc(2, 64'h0, SGISRE_OK, 32'h0);
      cmp("levels", 64'h0, {o_interface_enable, o_irq_bypass_disable,
         o_fiq_bypass_disable});
      cmp("fixed", 64'h7, {ro_en, ro_dib, ro_dfb});
      acc(1, 64'hFFFF_FFFF, SGISRE_OK, 32'h0);
      acc(2, 64'h0, SGISRE_OK, 32'h7);
      cmp("levels", 64'h7, {o_interface_enable, o_irq_bypass_disable,
         o_fiq_bypass_disable});
      {i_ctx.single_security_flag, i_ctx.mon_fiq_bypass_disable} = 2'h1;
      acc(2, 64'h0, SGISRE_OK, 32'h3);
      i_ctx.monitor_level_enable = 1'b0;
      acc(2, 64'h0, SGISRE_TRAP_MON, 32'h0);
      {i_ctx.monitor_level_enable, i_ctx.secure, i_virtual} = 3'h5;
      acc(2, 64'h0, SGISRE_VIRT, 32'h1);
      acc(1, 64'h0, SGISRE_VIRT, 32'h0);
      cmp("vwrite", 64'h2, {o_virt_enable_wr, o_virt_enable_val});
      i_virtual = 1'b0;
      acc(1, 64'h0, SGISRE_OK, 32'h0);
      acc(0, 64'h0, SGISRE_UNDEF, 32'h0);
      acc(3, 64'h0, SGISRE_UNDEF, 32'h0);
      acc(1, 64'h1, SGISRE_OK, 32'h0);
      acc(0, 64'h00A5_003C_097E_8001, SGISRE_OK, 32'h0);
      cmp("req", {4'h9, 1'b0, 40'hA5_3C7E_8001, 1'b0}, o_req);
      acc(0, 64'h00A5_013C_057E_8001, SGISRE_OK, 32'h0);
      cmp("req", {4'h5, 1'b1, 40'h0, 1'b0}, o_req);
      acc(0, 64'h0000_0000_0000_8000, SGISRE_OK, 32'h0);
      for (int n = 0; n < 6; n++) begin
         {i_ctx.hyp_fiq_route_override, i_ctx.hyp_irq_route_override,
            i_ctx.hyp_common_reg_trap, i_ctx.hyp_trap_group12} = 4'h8 >> n;
         {i_ctx.monitor_fiq_route, i_ctx.monitor_irq_route} = {2{n > 3}};
         i_ctx.secure = n > 3;
         i_ctx.el = n == 5 ? EL2 : EL1;
         acc(0, 64'h0, n > 3 ? SGISRE_TRAP_MON : SGISRE_TRAP_HYP,
            32'h0);
      end
      cmp("delivered", 64'h2, count);
      finish_test();
   end
endmodule : tb
